// ==== verilog/amux_pkg.sv ====
// constants, types and register map of the analog bus switch control
// assumes a 20 mhz system clock and a 32-bit apb register bus
package amux_pkg;

  // ---------------------------------------------------------------
  // clock and structure
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS     = 50;
  localparam int          PORTS_WITH_SWITCH = 6;
  localparam int          PINS_PER_PORT     = 8;
  localparam int          ADDR_W            = 8;
  localparam int          DIV_W             = 7;
  localparam int          SEL_W             = 3;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_PORT_EN_BASE  = 8'h00;
  localparam logic [7:0]  OFS_PRECHARGE_CFG = 8'h20;
  localparam logic [7:0]  OFS_CURRENT_CTRL  = 8'h24;
  localparam logic [7:0]  OFS_CURRENT_LEVEL = 8'h28;
  localparam logic [7:0]  OFS_STATUS        = 8'h2C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          CFG_SEL_LSB       = 1;
  localparam int          CFG_HOLD_LSB      = 4;
  localparam int          CUR_EN_BIT        = 0;
  localparam int          CUR_RANGE_BIT     = 3;
  localparam int          CUR_SPLIT_BIT     = 7;
  localparam int          STS_ACTIVE_BIT    = 0;
  localparam int          STS_PHASE_LSB     = 1;

  // port 0 pins that may serve as the integration node
  localparam int          HOLD_PIN_A        = 1;
  localparam int          HOLD_PIN_B        = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]        RST_PORT_EN = 8'h00;
  localparam logic [SEL_W-1:0]  RST_SEL     = 3'h0;
  localparam logic [1:0]        RST_HOLD    = 2'h0;
  localparam logic [7:0]        RST_LEVEL   = 8'h00;
  localparam logic [31:0]       RST_RDATA   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_SHARE   = 2'b00,
    PH_BREAK   = 2'b01,
    PH_CHARGE  = 2'b10,
    PH_RELEASE = 2'b11
  } phase_t;

  typedef enum logic [2:0] {
    RK_NONE   = 3'b000,
    RK_PORT   = 3'b001,
    RK_CFG    = 3'b010,
    RK_CUR    = 3'b011,
    RK_LEVEL  = 3'b100,
    RK_STATUS = 3'b101
  } reg_kind_t;

  typedef struct packed {
    logic       to_even;
    logic       to_odd;
    logic       high_range;
    logic [7:0] level;
  } current_drive_t;

endpackage

// ==== verilog/precharge_sequencer.sv ====
// precharge clock divider and break-before-make phase stepper
// assumes the caller gates its own outputs with the phase it gives
`timescale 1ns/1ps

module precharge_sequencer #(
  parameter int SEL_W = amux_pkg::SEL_W,
  parameter int DIV_W = amux_pkg::DIV_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [SEL_W-1:0] clk_sel,
  output amux_pkg::phase_t      phase,
  output logic                  active
);
  import amux_pkg::*;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  function automatic logic [DIV_W-1:0] div_limit(input logic [SEL_W-1:0] s);
    div_limit = DIV_W'((8'd1 << s) - 8'd1);
  endfunction

  logic [DIV_W-1:0] div_q;
  phase_t           phase_q;
  phase_t           phase_d;
  logic             tick;

  if (DIV_W < (1 << SEL_W) - 1) begin : g_chk
    $error("divider too narrow for the clock selection");
  end

  assign tick = (clk_sel != RST_SEL) && (div_q >= div_limit(clk_sel));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else if (ce) begin
      if (clk_sel == RST_SEL || tick) begin
        div_q <= '0;
      end else begin
        div_q <= DIV_W'(div_q + 1'b1);
      end
    end
  end

  // ---------------------------------------------------------------
  // phase stepper
  // ---------------------------------------------------------------
  always_comb begin
    phase_d = phase_q;
    if (clk_sel != RST_SEL) begin
      if (tick) begin
        phase_d = phase_t'(phase_q + 2'd1);
      end
    end else begin
      case (phase_q)
        PH_CHARGE:  phase_d = PH_RELEASE;
        PH_RELEASE: phase_d = PH_SHARE;
        PH_BREAK:   phase_d = PH_SHARE;
        default:    phase_d = PH_SHARE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_SHARE;
    end else if (ce) begin
      phase_q <= phase_d;
    end
  end

  assign phase  = phase_q;
  assign active = (clk_sel != RST_SEL) || (phase_q != PH_SHARE);

endmodule

// ==== verilog/amux_switch_ctrl.sv ====
// analog bus switch control: pin switches, precharge sequencing, split and current
// assumes an apb master on SYS_CLK and analog switches driven by the pin outputs
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps

module amux_switch_ctrl #(
  parameter int NUM_PORTS = amux_pkg::PORTS_WITH_SWITCH
) (
  input  wire logic                                   SYS_CLK,
  input  wire logic                                   RESET,
  input  wire logic                                   CE,
  input  wire logic                                   PSEL,
  input  wire logic                                   PENABLE,
  input  wire logic                                   PWRITE,
  input  wire logic [amux_pkg::ADDR_W-1:0]            PADDR,
  input  wire logic [31:0]                            PWDATA,
  output logic      [31:0]                            PRDATA,
  output logic                                        PREADY,
  output logic                                        PSLVERR,
  output logic      [NUM_PORTS*amux_pkg::PINS_PER_PORT-1:0] PIN_SWITCH,
  output logic      [NUM_PORTS*amux_pkg::PINS_PER_PORT-1:0] PIN_PRECHARGE,
  output logic                                        BUS_NETS_SHORTED,
  output amux_pkg::current_drive_t                    CHARGE_CURRENT
);
  import amux_pkg::*;

  localparam int PINS = NUM_PORTS * PINS_PER_PORT;

  if (NUM_PORTS < 1 || NUM_PORTS > PORTS_WITH_SWITCH) begin : g_chk
    $error("NUM_PORTS must lie between 1 and 6");
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic reg_kind_t decode(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'b00) begin
      decode = RK_NONE;
    end else if (a < OFS_PORT_EN_BASE + 8'(4 * NUM_PORTS)) begin
      decode = RK_PORT;
    end else if (a == OFS_PRECHARGE_CFG) begin
      decode = RK_CFG;
    end else if (a == OFS_CURRENT_CTRL) begin
      decode = RK_CUR;
    end else if (a == OFS_CURRENT_LEVEL) begin
      decode = RK_LEVEL;
    end else if (a == OFS_STATUS) begin
      decode = RK_STATUS;
    end else begin
      decode = RK_NONE;
    end
  endfunction

  reg_kind_t         kind;
  logic [2:0]        port_idx;
  logic              wr_fire;

  assign kind     = decode(PADDR);
  assign port_idx = PADDR[4:2];
  assign PREADY   = CE;
  assign PSLVERR  = PSEL && PENABLE && (kind == RK_NONE);
  assign wr_fire  = CE && PSEL && PENABLE && PWRITE && (kind != RK_NONE);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]        en_q [NUM_PORTS];
  logic [SEL_W-1:0]  sel_q;
  logic [1:0]        hold_q;
  logic              split_q;
  logic              cur_en_q;
  logic              range_q;
  logic [7:0]        level_q;
  phase_t            phase;
  logic              active;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        en_q[p] <= RST_PORT_EN;
      end
    end else if (wr_fire && kind == RK_PORT) begin
      en_q[port_idx] <= PWDATA[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sel_q  <= RST_SEL;
      hold_q <= RST_HOLD;
    end else if (wr_fire && kind == RK_CFG) begin
      sel_q  <= PWDATA[CFG_SEL_LSB +: SEL_W];
      hold_q <= PWDATA[CFG_HOLD_LSB +: 2];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      split_q  <= 1'b0;
      cur_en_q <= 1'b0;
      range_q  <= 1'b0;
    end else if (wr_fire && kind == RK_CUR) begin
      split_q  <= PWDATA[CUR_SPLIT_BIT];
      cur_en_q <= PWDATA[CUR_EN_BIT];
      range_q  <= PWDATA[CUR_RANGE_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      level_q <= RST_LEVEL;
    end else if (wr_fire && kind == RK_LEVEL) begin
      level_q <= PWDATA[7:0];
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = RST_RDATA;
    case (kind)
      RK_PORT:   rdata_d[7:0] = en_q[port_idx];
      RK_CFG: begin
        rdata_d[CFG_SEL_LSB +: SEL_W] = sel_q;
        rdata_d[CFG_HOLD_LSB +: 2]    = hold_q;
      end
      RK_CUR: begin
        rdata_d[CUR_SPLIT_BIT] = split_q;
        rdata_d[CUR_EN_BIT]    = cur_en_q;
        rdata_d[CUR_RANGE_BIT] = range_q;
      end
      RK_LEVEL:  rdata_d[7:0] = level_q;
      RK_STATUS: begin
        rdata_d[STS_ACTIVE_BIT]     = active;
        rdata_d[STS_PHASE_LSB +: 2] = phase;
      end
      default:   rdata_d = RST_RDATA;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= RST_RDATA;
    end else if (CE && PSEL && !PWRITE) begin
      PRDATA <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // precharge sequencing
  // ---------------------------------------------------------------
  precharge_sequencer #(
    .SEL_W   (SEL_W),
    .DIV_W   (DIV_W)
  ) u_seq (
    .clk     (SYS_CLK),
    .rst     (RESET),
    .ce      (CE),
    .clk_sel (sel_q),
    .phase   (phase),
    .active  (active)
  );

  // ---------------------------------------------------------------
  // pin switch drive
  // ---------------------------------------------------------------
  logic [PINS-1:0] hold_vec;
  logic [PINS-1:0] en_vec;
  logic [PINS-1:0] sw_d;
  logic [PINS-1:0] pc_d;

  always_comb begin
    hold_vec = '0;
    hold_vec[HOLD_PIN_A] = hold_q[0];
    hold_vec[HOLD_PIN_B] = hold_q[1];
    for (int p = 0; p < NUM_PORTS; p++) begin
      en_vec[p*PINS_PER_PORT +: PINS_PER_PORT] = en_q[p];
    end
  end

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      sw_d[i] = en_vec[i] && (!active || hold_vec[i] || phase == PH_SHARE);
      pc_d[i] = en_vec[i] && active && !hold_vec[i] && phase == PH_CHARGE;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      PIN_SWITCH    <= '0;
      PIN_PRECHARGE <= '0;
    end else if (CE) begin
      PIN_SWITCH    <= sw_d;
      PIN_PRECHARGE <= pc_d;
    end
  end

  // ---------------------------------------------------------------
  // split and charging current
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      BUS_NETS_SHORTED <= 1'b1;
      CHARGE_CURRENT   <= '0;
    end else if (CE) begin
      BUS_NETS_SHORTED          <= !split_q;
      CHARGE_CURRENT.to_even    <= cur_en_q;
      CHARGE_CURRENT.to_odd     <= cur_en_q && !split_q;
      CHARGE_CURRENT.high_range <= range_q;
      CHARGE_CURRENT.level      <= level_q;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  a_reset_open: assert property (
    $past(RESET) |-> (PIN_SWITCH == '0) && (PIN_PRECHARGE == '0))
    else $error("pin switch closed right after reset");

  a_static_follow: assert property (
    $past(CE) && !$past(active) |-> PIN_SWITCH == $past(en_vec) && PIN_PRECHARGE == '0)
    else $error("static mode switch differs from enable bits");

  a_no_overlap: assert property (
    (PIN_SWITCH & PIN_PRECHARGE) == '0)
    else $error("pin precharged while connected");

  a_break_open: assert property (
    $past(CE) && $past(phase) == PH_BREAK |-> (PIN_SWITCH & ~$past(hold_vec)) == '0)
    else $error("switch closed in break phase");

  a_phase_step: assert property (
    CE && sel_q != RST_SEL && $past(sel_q) == sel_q && phase != $past(phase)
    |-> phase == phase_t'($past(phase) + 2'd1))
    else $error("phase skipped a step");

  a_hold_connected: assert property (
    $past(CE) |-> (($past(hold_vec) & $past(en_vec)) & ~PIN_SWITCH) == '0)
    else $error("integration node switch opened");

  a_current_even: assert property (
    CHARGE_CURRENT.to_odd |-> CHARGE_CURRENT.to_even && BUS_NETS_SHORTED)
    else $error("current on odd net while split");

  a_current_off: assert property (
    $past(CE) && !$past(cur_en_q) |-> !CHARGE_CURRENT.to_even && !CHARGE_CURRENT.to_odd)
    else $error("current connected while disabled");

  a_no_port6: assert property (
    PSEL && PENABLE && PADDR == OFS_PORT_EN_BASE + 8'(4 * NUM_PORTS) |-> PSLVERR)
    else $error("port without switch accepted");

  a_enable_write: assert property (
    wr_fire && kind == RK_PORT |=> en_q[$past(port_idx)] == 8'($past(PWDATA)))
    else $error("enable write lost");

  c_static_connect: cover property (!active && PIN_SWITCH != '0);
  c_full_cycle: cover property (phase == PH_RELEASE ##[1:300] phase == PH_SHARE);
  c_split_current: cover property (CHARGE_CURRENT.to_even && !BUS_NETS_SHORTED);

endmodule

// ==== verif/amux_pins_model.sv ====
// pins and capacitors hanging on the analog bus nets
// assumes even pin index on the even net, odd index on the odd net
`timescale 1ns/1ps

module amux_pins_model #(
  parameter int PINS = 48,
  parameter int NODE = 1
) (
  input  wire logic            SYS_CLK,
  input  wire logic            RESET,
  input  wire logic            NODE_INIT_LOW,
  input  wire logic [PINS-1:0] PIN_SWITCH,
  input  wire logic [PINS-1:0] PIN_PRECHARGE,
  input  wire logic            BUS_NETS_SHORTED,
  output logic      [PINS-1:0] CAP_HIGH,
  output logic                 DISTURB
);
  // ---------------------------------------------------------------
  // net levels and charge sharing
  // ---------------------------------------------------------------
  logic [1:0] net_high;
  logic [1:0] shared;

  always_comb begin
    net_high = 2'b00;
    for (int i = 0; i < PINS; i++) begin
      if (PIN_SWITCH[i] && CAP_HIGH[i]) begin
        net_high[i%2] = 1'b1;
      end
    end
    shared = BUS_NETS_SHORTED ? {2{|net_high}} : net_high;
    DISTURB = |(PIN_SWITCH & PIN_PRECHARGE);
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      CAP_HIGH <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (PIN_PRECHARGE[i]) begin
          CAP_HIGH[i] <= 1'b1;
        end else if (i == NODE && NODE_INIT_LOW) begin
          CAP_HIGH[i] <= 1'b0;
        end else if (PIN_SWITCH[i] && shared[i%2]) begin
          CAP_HIGH[i] <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== verif/tb_amux_switch_ctrl.sv ====
// self-checking bench for the analog bus switch control
// assumes the pin model beside the design and a 50 ns clock
`timescale 1ns/1ps

module tb_amux_switch_ctrl;
  import amux_pkg::*;

  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam int PINS = PORTS_WITH_SWITCH * PINS_PER_PORT;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        err;
  } row_t;
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  logic              ce = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic              node_init_low = 1'b0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [PINS-1:0]   pin_switch;
  logic [PINS-1:0]   pin_precharge;
  logic              shorted;
  current_drive_t    cur_drive;
  logic [PINS-1:0]   cap_high;
  logic              disturb;
  int                fail_count = 0;
  int                total_checks = 0;
  row_t              rows [9] = '{
    '{8'h00, 32'hFFFF_FF81, 32'h0000_0081, 1'b0}, '{8'h04, 32'h0000_0042, 32'h0000_0042, 1'b0},
    '{8'h08, 32'h0000_0024, 32'h0000_0024, 1'b0}, '{8'h0C, 32'h0000_0018, 32'h0000_0018, 1'b0},
    '{8'h10, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{8'h14, 32'h0000_0080, 32'h0000_0080, 1'b0},
    '{8'h18, 32'h0000_00FF, 32'h0000_0000, 1'b1}, '{8'h01, 32'h0000_00FF, 32'h0000_0000, 1'b1},
    '{8'h2C, 32'h0000_00FF, 32'h0000_0000, 1'b0}};
  logic [31:0]       cur_wr [3] = '{32'h0000_0080, 32'h0000_0089, 32'h0000_0009};
  logic [2:0]        cur_exp [3] = '{3'b000, 3'b010, 3'b111};

  amux_switch_ctrl u_amux_switch_ctrl (
    .SYS_CLK(sys_clk), .RESET(reset), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_SWITCH(pin_switch), .PIN_PRECHARGE(pin_precharge),
    .BUS_NETS_SHORTED(shorted), .CHARGE_CURRENT(cur_drive));

  amux_pins_model u_amux_pins_model (
    .SYS_CLK(sys_clk), .RESET(reset), .NODE_INIT_LOW(node_init_low),
    .PIN_SWITCH(pin_switch), .PIN_PRECHARGE(pin_precharge),
    .BUS_NETS_SHORTED(shorted), .CAP_HIGH(cap_high), .DISTURB(disturb));

  always #25 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    logic        prev_pre;
    int          last;
    int          rises;
    logic [2*PINS-1:0] snap;
    logic        seen;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check(pin_switch | pin_precharge, '0);
    check({shorted, cur_drive}, {1'b1, 11'h000});
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wdata, r, e);
      check(e, rows[i].err);
      apb(1'b0, rows[i].addr, '0, r, e);
      check({e, r}, {rows[i].err, rows[i].rdata});
    end
    settle(2);
    check(pin_switch, 48'h8000_1824_4281);
    check(pin_precharge, '0);
    apb(1'b1, OFS_CURRENT_LEVEL, 32'h0000_005A, r, e);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_CURRENT_CTRL, cur_wr[k], r, e);
      settle(2);
      check({shorted, cur_drive.to_even, cur_drive.to_odd}, cur_exp[k]);
    end
    check({cur_drive.high_range, cur_drive.level}, 9'h15A);
    apb(1'b1, OFS_CURRENT_CTRL, '0, r, e);
    apb(1'b1, OFS_PORT_EN_BASE, 32'h0000_0083, r, e);
    for (int s = 1; s < 8; s++) begin
      apb(1'b1, OFS_PRECHARGE_CFG, 32'(s << CFG_SEL_LSB), r, e);
      apb(1'b0, OFS_STATUS, '0, r, e);
      check(r[STS_ACTIVE_BIT], 1'b1);
    end
    apb(1'b1, OFS_PRECHARGE_CFG, '0, r, e);
    node_init_low <= 1'b1;
    repeat (8) @(posedge sys_clk);
    node_init_low <= 1'b0;
    apb(1'b1, OFS_PRECHARGE_CFG, 32'h0000_0012, r, e);
    last = -1;
    rises = 0;
    prev_pre = 1'b0;
    for (int c = 0; c < 48; c++) begin
      @(negedge sys_clk);
      check(disturb, 1'b0);
      check({pin_switch[1], pin_precharge[1]}, 2'b10);
      if (prev_pre) begin
        check(pin_switch[0], 1'b0);
      end
      if (pin_precharge[0] && !prev_pre) begin
        if (last >= 0) begin
          check(c - last, 8);
        end
        last = c;
        rises++;
      end
      prev_pre = pin_precharge[0];
    end
    check(rises >= 5, 1'b1);
    check(cap_high[1], 1'b1);
    @(posedge sys_clk);
    ce <= 1'b0;
    @(negedge sys_clk);
    snap = {pin_switch, pin_precharge};
    repeat (6) @(negedge sys_clk);
    check(pready, 1'b0);
    check({pin_switch, pin_precharge} == snap, 1'b1);
    @(posedge sys_clk);
    ce <= 1'b1;
    apb(1'b1, OFS_PRECHARGE_CFG, '0, r, e);
    settle(8);
    check(pin_switch[7:0], 8'h83);
    check(pin_precharge, '0);
    apb(1'b0, OFS_STATUS, '0, r, e);
    check(r, '0);
    apb(1'b1, OFS_PORT_EN_BASE, 32'h0000_008B, r, e);
    apb(1'b1, OFS_PRECHARGE_CFG, 32'h0000_0022, r, e);
    settle(1);
    seen = 1'b0;
    for (int c = 0; c < 16; c++) begin
      @(negedge sys_clk);
      check({pin_switch[3], pin_precharge[3]}, 2'b10);
      seen = seen | pin_precharge[1];
    end
    check(seen, 1'b1);
    @(posedge sys_clk);
    reset <= 1'b1;
    @(negedge sys_clk);
    check({pin_switch, shorted}, {48'h0, 1'b1});
    check(pin_precharge, '0);
    @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, OFS_PORT_EN_BASE, '0, r, e);
    check(r, '0);
    conclude();
  end
endmodule
